/* core/insn_exec_pkg.sv */
// Package with constants and types for the four-instruction execution block.
`default_nettype none
package insn_exec_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the APB.
  localparam logic [11:0] OFS_ISSUE   = 12'h000;
  localparam logic [11:0] OFS_WORK    = 12'h004;
  localparam logic [11:0] OFS_STATUS  = 12'h008;
  localparam logic [11:0] OFS_WDOG    = 12'h00C;
  localparam logic [11:0] OFS_PRESC   = 12'h010;
  localparam logic [11:0] OFS_CONFIG  = 12'h014;
  localparam logic [11:0] OFS_CYCLES  = 12'h018;
  localparam logic [11:0] OFS_FILE    = 12'h200;
  localparam logic [2:0]  FILE_SEL    = 3'h1;

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions.
  localparam int ISSUE_OP_LSB  = 0;
  localparam int ISSUE_DST_BIT = 2;
  localparam int ISSUE_ADR_LSB = 3;
  localparam int ST_CARRY_BIT  = 0;
  localparam int ST_ZERO_BIT   = 1;
  localparam int ST_TOUT_BIT   = 2;
  localparam int ST_PDWN_BIT   = 3;
  localparam int ST_BUSY_BIT   = 4;
  localparam int ST_SKIP_BIT   = 5;
  localparam int ADDR_W        = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [7:0]  RST_WORK   = 8'h00;
  localparam logic [7:0]  RST_COUNT  = 8'h00;
  localparam logic        RST_FLAG1  = 1'b1;
  localparam logic        RST_FLAG0  = 1'b0;
  localparam logic [15:0] RST_CYCLES = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////////
  // Operations and execution states.
  typedef enum logic [1:0] {
    OP_KICK,
    OP_COMPARE,
    OP_DEC_ADJ,
    OP_DEC_SKIP
  } op_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_SQUASH
  } exec_state_t;

endpackage
`default_nettype wire

/* core/insn_exec.sv */
// Execution unit for watchdog kick, compare, decimal adjust and decrement-skip.
`timescale 1ns/1ns
`default_nettype none
module insn_exec #(
  parameter int FILE_DEPTH = 128
) (
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RESETN_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT
);

  // The file is addressed by a seven-bit direct operand only.
  if (FILE_DEPTH != 128) begin : g_depth_check
    $error("FILE_DEPTH must be 128 for a seven-bit direct address.");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  logic [7:0]  file_mem [FILE_DEPTH];
  insn_exec_pkg::exec_state_t state_r, state_nxt;
  insn_exec_pkg::op_t         op_r, op_nxt;
  logic                       dst_r, dst_nxt;
  logic [6:0]                 adr_r, adr_nxt;
  logic [7:0]                 work_r, work_nxt;
  logic                       carry_r, carry_nxt;
  logic                       zero_r, zero_nxt;
  logic                       tout_r, tout_nxt;
  logic                       pdwn_r, pdwn_nxt;
  logic                       skip_r, skip_nxt;
  logic                       assign_r, assign_nxt;
  logic [7:0]                 wdog_r, wdog_nxt;
  logic [7:0]                 presc_r, presc_nxt;
  logic [15:0]                cycles_r, cycles_nxt;
  logic [31:0]                rdata_r, rdata_nxt;
  logic                       ready_r, ready_nxt;
  logic                       slverr_r, slverr_nxt;
  logic                       mem_we;
  logic [6:0]                 mem_adr;
  logic [7:0]                 mem_wdata;
  logic [7:0]                 file_val;
  logic [7:0]                 dec_val;
  logic [7:0]                 daa_val;
  logic                       daa_carry;
  logic                       access;
  logic                       take;
  logic                       in_file;
  logic                       exec;

  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RESETN_IN);

  ////////////////////////////////////////////////////////////////////////////////
  // Operand fetch and arithmetic shared by the operations.
  assign access   = PSEL_IN && PENABLE_IN && !ready_r;
  assign take     = access && (state_r == insn_exec_pkg::ST_IDLE);
  assign in_file  = (PADDR_IN[11:9] == insn_exec_pkg::FILE_SEL);
  assign exec     = (state_r == insn_exec_pkg::ST_EXEC);
  assign file_val = file_mem[adr_r];
  assign dec_val  = file_val - 8'h01;

  // Decimal correction of the low digit, then of the high digit with carry in.
  always_comb begin
    logic [8:0] tmp;
    tmp       = {1'b0, work_r};
    if (tmp[3:0] > 4'h9) begin
      tmp = tmp + 9'h006;
    end
    if ((tmp[8:4] > 5'h09) || carry_r) begin
      tmp = tmp + 9'h060;
    end
    daa_val   = tmp[7:0];
    daa_carry = tmp[8] || carry_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic for execution, flags, watchdog and the bus slave.
  always_comb begin
    state_nxt  = state_r;
    op_nxt     = op_r;
    dst_nxt    = dst_r;
    adr_nxt    = adr_r;
    work_nxt   = work_r;
    carry_nxt  = carry_r;
    zero_nxt   = zero_r;
    tout_nxt   = tout_r;
    pdwn_nxt   = pdwn_r;
    skip_nxt   = skip_r;
    assign_nxt = assign_r;
    cycles_nxt = cycles_r;
    mem_we     = 1'b0;
    mem_adr    = adr_r;
    mem_wdata  = dec_val;
    rdata_nxt  = rdata_r;
    ready_nxt  = 1'b0;
    slverr_nxt = 1'b0;
    // Free-running watchdog; through the prescaler when it is assigned.
    presc_nxt  = presc_r + 8'h01;
    wdog_nxt   = (!assign_r || presc_r == 8'hFF) ? wdog_r + 8'h01 : wdog_r;

    // Execution of the latched operation.
    case (state_r)
      insn_exec_pkg::ST_EXEC: begin
        cycles_nxt = cycles_r + 16'h0001;
        state_nxt  = insn_exec_pkg::ST_IDLE;
        skip_nxt   = 1'b0;
        case (op_r)
          insn_exec_pkg::OP_KICK: begin
            wdog_nxt = insn_exec_pkg::RST_COUNT;
            if (assign_r) begin
              presc_nxt = insn_exec_pkg::RST_COUNT;
            end
            tout_nxt = 1'b1;
            pdwn_nxt = 1'b1;
          end
          insn_exec_pkg::OP_COMPARE: begin
            carry_nxt = (file_val >= work_r);
            zero_nxt  = (file_val == work_r);
          end
          insn_exec_pkg::OP_DEC_ADJ: begin
            work_nxt  = daa_val;
            carry_nxt = daa_carry;
          end
          default: begin
            if (dst_r) begin
              mem_we = 1'b1;
            end else begin
              work_nxt = dec_val;
            end
            if (dec_val == 8'h00) begin
              state_nxt = insn_exec_pkg::ST_SQUASH;
              skip_nxt  = 1'b1;
            end
          end
        endcase
      end
      insn_exec_pkg::ST_SQUASH: begin
        cycles_nxt = cycles_r + 16'h0001;
        state_nxt  = insn_exec_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = insn_exec_pkg::ST_IDLE;
      end
    endcase

    // Bus access: held in wait states while an operation runs.
    if (take) begin
      ready_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (in_file) begin
        mem_adr = PADDR_IN[8:2];
        if (PWRITE_IN) begin
          mem_we    = 1'b1;
          mem_wdata = PWDATA_IN[7:0];
        end else begin
          rdata_nxt = {24'h000000, file_mem[PADDR_IN[8:2]]};
        end
      end else if (PADDR_IN == insn_exec_pkg::OFS_ISSUE) begin
        if (PWRITE_IN) begin
          op_nxt    = insn_exec_pkg::op_t'(PWDATA_IN[insn_exec_pkg::ISSUE_OP_LSB +: 2]);
          dst_nxt   = PWDATA_IN[insn_exec_pkg::ISSUE_DST_BIT];
          adr_nxt   = PWDATA_IN[insn_exec_pkg::ISSUE_ADR_LSB +: insn_exec_pkg::ADDR_W];
          state_nxt = insn_exec_pkg::ST_EXEC;
        end else begin
          rdata_nxt = {22'h0, adr_r, dst_r, op_r};
        end
      end else if (PADDR_IN == insn_exec_pkg::OFS_WORK) begin
        if (PWRITE_IN) begin
          work_nxt = PWDATA_IN[7:0];
        end
        rdata_nxt = {24'h000000, work_r};
      end else if (PADDR_IN == insn_exec_pkg::OFS_STATUS) begin
        if (PWRITE_IN) begin
          carry_nxt = PWDATA_IN[insn_exec_pkg::ST_CARRY_BIT];
          zero_nxt  = PWDATA_IN[insn_exec_pkg::ST_ZERO_BIT];
          tout_nxt  = PWDATA_IN[insn_exec_pkg::ST_TOUT_BIT];
          pdwn_nxt  = PWDATA_IN[insn_exec_pkg::ST_PDWN_BIT];
        end
        rdata_nxt = {26'h0, skip_r, 1'b0, pdwn_r, tout_r, zero_r, carry_r};
      end else if (PADDR_IN == insn_exec_pkg::OFS_WDOG) begin
        rdata_nxt = {24'h000000, wdog_r};
        slverr_nxt = PWRITE_IN;
      end else if (PADDR_IN == insn_exec_pkg::OFS_PRESC) begin
        rdata_nxt = {24'h000000, presc_r};
        slverr_nxt = PWRITE_IN;
      end else if (PADDR_IN == insn_exec_pkg::OFS_CONFIG) begin
        if (PWRITE_IN) begin
          assign_nxt = PWDATA_IN[0];
        end
        rdata_nxt = {31'h0, assign_r};
      end else if (PADDR_IN == insn_exec_pkg::OFS_CYCLES) begin
        rdata_nxt = {16'h0000, cycles_r};
        slverr_nxt = PWRITE_IN;
      end else begin
        slverr_nxt = 1'b1;
      end
    end
  end

  // Register all control state.
  always_ff @(posedge CLK_SYS_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_r  <= insn_exec_pkg::ST_IDLE;
      op_r     <= insn_exec_pkg::OP_KICK;
      dst_r    <= 1'b0;
      adr_r    <= 7'h00;
      work_r   <= insn_exec_pkg::RST_WORK;
      carry_r  <= insn_exec_pkg::RST_FLAG0;
      zero_r   <= insn_exec_pkg::RST_FLAG0;
      tout_r   <= insn_exec_pkg::RST_FLAG1;
      pdwn_r   <= insn_exec_pkg::RST_FLAG1;
      skip_r   <= insn_exec_pkg::RST_FLAG0;
      assign_r <= insn_exec_pkg::RST_FLAG0;
      wdog_r   <= insn_exec_pkg::RST_COUNT;
      presc_r  <= insn_exec_pkg::RST_COUNT;
      cycles_r <= insn_exec_pkg::RST_CYCLES;
      rdata_r  <= 32'h0000_0000;
      ready_r  <= 1'b0;
      slverr_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      op_r     <= op_nxt;
      dst_r    <= dst_nxt;
      adr_r    <= adr_nxt;
      work_r   <= work_nxt;
      carry_r  <= carry_nxt;
      zero_r   <= zero_nxt;
      tout_r   <= tout_nxt;
      pdwn_r   <= pdwn_nxt;
      skip_r   <= skip_nxt;
      assign_r <= assign_nxt;
      wdog_r   <= wdog_nxt;
      presc_r  <= presc_nxt;
      cycles_r <= cycles_nxt;
      rdata_r  <= rdata_nxt;
      ready_r  <= ready_nxt;
      slverr_r <= slverr_nxt;
    end
  end

  // Data memory has no reset; software initialises it.
  always_ff @(posedge CLK_SYS_IN) begin
    if (mem_we) begin
      file_mem[mem_adr] <= mem_wdata;
    end
  end

  assign PRDATA_OUT  = rdata_r;
  assign PREADY_OUT  = ready_r;
  assign PSLVERR_OUT = slverr_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the execution behaviour.
  sequence s_dec_zero;
    exec && op_r == insn_exec_pkg::OP_DEC_SKIP && file_val == 8'h01;
  endsequence

  sequence s_squash_then_idle;
    state_r == insn_exec_pkg::ST_SQUASH ##1 state_r == insn_exec_pkg::ST_IDLE;
  endsequence

  property p_kick_clear;
    exec && op_r == insn_exec_pkg::OP_KICK |=> wdog_r == 8'h00 &&
      (!$past(assign_r) || presc_r == 8'h00);
  endproperty
  a_kick_clear: assert property (p_kick_clear) else $error("Kick left a count.");

  property p_kick_flags;
    exec && op_r == insn_exec_pkg::OP_KICK |=> tout_r && pdwn_r && $stable(carry_r) &&
      $stable(zero_r);
  endproperty
  a_kick_flags: assert property (p_kick_flags) else $error("Kick flags wrong.");

  property p_cmp_flags;
    exec && op_r == insn_exec_pkg::OP_COMPARE |=> carry_r == ($past(file_val) >= $past(work_r))
      && zero_r == ($past(file_val) == $past(work_r)) && state_r == insn_exec_pkg::ST_IDLE;
  endproperty
  a_cmp_flags: assert property (p_cmp_flags) else $error("Compare flags wrong.");

  property p_cmp_keep;
    exec && op_r == insn_exec_pkg::OP_COMPARE |-> !mem_we ##1 $stable(work_r);
  endproperty
  a_cmp_keep: assert property (p_cmp_keep) else $error("Compare changed data.");

  property p_daa;
    exec && op_r == insn_exec_pkg::OP_DEC_ADJ |=> work_r[3:0] <= 4'h9 &&
      ($past(carry_r) || work_r[7:4] <= 4'h9) && $stable(zero_r) && $stable(tout_r) &&
      $stable(pdwn_r);
  endproperty
  a_daa: assert property (p_daa) else $error("Decimal adjust wrong.");

  property p_dec_work;
    exec && op_r == insn_exec_pkg::OP_DEC_SKIP && !dst_r |-> !mem_we ##1
      work_r == 8'($past(file_val) - 8'h01);
  endproperty
  a_dec_work: assert property (p_dec_work) else $error("Decrement to working wrong.");

  property p_dec_file;
    exec && op_r == insn_exec_pkg::OP_DEC_SKIP && dst_r |-> mem_we && mem_adr == adr_r &&
      mem_wdata == 8'(file_val - 8'h01) ##1 $stable(work_r);
  endproperty
  a_dec_file: assert property (p_dec_file) else $error("Decrement to file wrong.");

  property p_skip;
    s_dec_zero |=> s_squash_then_idle;
  endproperty
  a_skip: assert property (p_skip) else $error("Skip cycle missing.");

  property p_noskip;
    exec && op_r == insn_exec_pkg::OP_DEC_SKIP && file_val != 8'h01 |=>
      state_r == insn_exec_pkg::ST_IDLE && cycles_r == $past(cycles_r) + 16'h0001;
  endproperty
  a_noskip: assert property (p_noskip) else $error("Extra cycle without skip.");

  property p_issue_adr;
    take && PWRITE_IN && PADDR_IN == insn_exec_pkg::OFS_ISSUE |=>
      adr_r == $past(PWDATA_IN[9:3]) && state_r == insn_exec_pkg::ST_EXEC;
  endproperty
  a_issue_adr: assert property (p_issue_adr) else $error("Operand address wrong.");

endmodule
`default_nettype wire

/* dv/testbench.sv */
// Self-checking testbench for the four-instruction execution block over APB.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [1:0] op;
    logic       dst;
    logic [6:0] adr;
    logic [7:0] fv;
    logic [7:0] wv;
    logic [3:0] st;
    logic [7:0] ew;
    logic [7:0] ef;
    logic [3:0] es;
    logic       sk;
  } row_t;

  logic        clk;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          err_total;
  int          checks_done;
  row_t        rows [11];

  insn_exec insn_exec_inst (
    .CLK_SYS_IN  (clk),
    .RESETN_IN   (resetn),
    .PSEL_IN     (psel),
    .PENABLE_IN  (penable),
    .PWRITE_IN   (pwrite),
    .PADDR_IN    (paddr),
    .PWDATA_IN   (pwdata),
    .PRDATA_OUT  (prdata),
    .PREADY_OUT  (pready),
    .PSLVERR_OUT (pslverr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock with a 100 ns period.
  always #50 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb_xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                          output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      $display("CHECK FAILED pready expected 1 seen %b", pready);
      err_total++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask

  // Write that must be accepted without an error response.
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        e;
    apb_xfer(1'h1, a, d, rd, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  // Read that must be accepted and return the expected word.
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input string nm);
    logic [31:0] rd;
    logic        e;
    apb_xfer(1'h0, a, 32'h0, rd, e);
    chk(nm, x, rd);
    chk("read error", 32'h0, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of operations, then hand-written cases.
  initial begin
    logic [31:0] d;
    logic [31:0] c0;
    logic        e;
    logic [11:0] fa;
    row_t        r;
    clk = 1'h0;
    resetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    err_total = 0;
    checks_done = 0;
    rows[0]  = {2'h1, 1'h0, 7'h05, 8'h34, 8'h12, 4'h0, 8'h12, 8'h34, 4'h1, 1'h0};
    rows[1]  = {2'h1, 1'h0, 7'h7F, 8'h55, 8'h55, 4'h0, 8'h55, 8'h55, 4'h3, 1'h0};
    rows[2]  = {2'h1, 1'h1, 7'h00, 8'h10, 8'h20, 4'hF, 8'h20, 8'h10, 4'hC, 1'h0};
    rows[3]  = {2'h0, 1'h0, 7'h01, 8'hAA, 8'hBB, 4'h3, 8'hBB, 8'hAA, 4'hF, 1'h0};
    rows[4]  = {2'h2, 1'h0, 7'h02, 8'h00, 8'h4D, 4'h2, 8'h53, 8'h00, 4'h2, 1'h0};
    rows[5]  = {2'h2, 1'h0, 7'h02, 8'h00, 8'h9A, 4'h0, 8'h00, 8'h00, 4'h1, 1'h0};
    rows[6]  = {2'h2, 1'h0, 7'h02, 8'h00, 8'h00, 4'h1, 8'h60, 8'h00, 4'h1, 1'h0};
    rows[7]  = {2'h3, 1'h0, 7'h10, 8'h05, 8'h77, 4'h0, 8'h04, 8'h05, 4'h0, 1'h0};
    rows[8]  = {2'h3, 1'h1, 7'h11, 8'h01, 8'h77, 4'h0, 8'h77, 8'h00, 4'h0, 1'h1};
    rows[9]  = {2'h3, 1'h0, 7'h12, 8'h01, 8'h77, 4'h3, 8'h00, 8'h01, 4'h3, 1'h1};
    rows[10] = {2'h3, 1'h1, 7'h7E, 8'h00, 8'h77, 4'h0, 8'h77, 8'hFF, 4'h0, 1'h0};
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    rd_chk(insn_exec_pkg::OFS_STATUS, 32'h0000000C, "status after reset");
    rd_chk(insn_exec_pkg::OFS_WORK, 32'h0, "work after reset");
    rd_chk(insn_exec_pkg::OFS_CYCLES, 32'h0, "cycles after reset");
    // Each row presets file, working register and flags, issues one operation, checks all.
    foreach (rows[i]) begin
      r = rows[i];
      fa = insn_exec_pkg::OFS_FILE + {3'h0, r.adr, 2'h0};
      wr_reg(fa, {24'h0, r.fv});
      wr_reg(insn_exec_pkg::OFS_WORK, {24'h0, r.wv});
      wr_reg(insn_exec_pkg::OFS_STATUS, {28'h0, r.st});
      apb_xfer(1'h0, insn_exec_pkg::OFS_CYCLES, 32'h0, c0, e);
      wr_reg(insn_exec_pkg::OFS_ISSUE, {22'h0, r.adr, r.dst, r.op});
      rd_chk(insn_exec_pkg::OFS_WORK, {24'h0, r.ew}, "work");
      rd_chk(fa, {24'h0, r.ef}, "file slot");
      rd_chk(insn_exec_pkg::OFS_STATUS, {26'h0, r.sk, 1'h0, r.es}, "status");
      apb_xfer(1'h0, insn_exec_pkg::OFS_CYCLES, 32'h0, d, e);
      chk("cycles", c0 + 32'h1 + {31'h0, r.sk}, d);
    end
    // Unmapped read and a write to a read-only place are refused.
    apb_xfer(1'h0, 12'h020, 32'h0, d, e);
    chk("unmapped data", 32'h0, d);
    chk("unmapped error", 32'h1, {31'h0, e});
    apb_xfer(1'h1, insn_exec_pkg::OFS_WDOG, 32'h55, d, e);
    chk("read-only error", 32'h1, {31'h0, e});
    // Kick with the prescaler assigned clears both counts.
    wr_reg(insn_exec_pkg::OFS_CONFIG, 32'h1);
    repeat (600) @(posedge clk);
    wr_reg(insn_exec_pkg::OFS_ISSUE, 32'h0);
    rd_chk(insn_exec_pkg::OFS_WDOG, 32'h0, "watchdog count");
    apb_xfer(1'h0, insn_exec_pkg::OFS_PRESC, 32'h0, d, e);
    chk("prescaler small", 32'h1, {31'h0, d < 32'h10});
    // Kick without the prescaler assigned still restarts the count.
    wr_reg(insn_exec_pkg::OFS_CONFIG, 32'h0);
    repeat (200) @(posedge clk);
    wr_reg(insn_exec_pkg::OFS_ISSUE, 32'h0);
    apb_xfer(1'h0, insn_exec_pkg::OFS_WDOG, 32'h0, d, e);
    chk("watchdog small", 32'h1, {31'h0, d < 32'h10});
    // Mid-run reset returns flags, working register, config and cycle count to reset values.
    wr_reg(insn_exec_pkg::OFS_CONFIG, 32'h1);
    wr_reg(insn_exec_pkg::OFS_STATUS, 32'h0);
    resetn <= 1'h0;
    repeat (2) @(posedge clk);
    chk("pready in reset", 32'h0, {31'h0, pready});
    chk("prdata in reset", 32'h0, prdata);
    chk("pslverr in reset", 32'h0, {31'h0, pslverr});
    resetn <= 1'h1;
    rd_chk(insn_exec_pkg::OFS_STATUS, 32'h0000000C, "status after second reset");
    rd_chk(insn_exec_pkg::OFS_WORK, 32'h0, "work after second reset");
    rd_chk(insn_exec_pkg::OFS_CONFIG, 32'h0, "config after second reset");
    rd_chk(insn_exec_pkg::OFS_CYCLES, 32'h0, "cycles after second reset");
    tally_and_finish();
  end
endmodule
`default_nettype wire
